// file: ccm_params.svh
`ifndef CCM_PARAMS_SVH
`define CCM_PARAMS_SVH
// Register byte offsets, one aligned word each
`define CCM_ADDR_W 6
`define CCM_OFS_FLAGS 6'h00
`define CCM_OFS_ENABLES 6'h04
`define CCM_OFS_PRIORITY 6'h08
`define CCM_OFS_T3CTL 6'h0C
`define CCM_OFS_U1_LO 6'h10
`define CCM_OFS_U1_HI 6'h14
`define CCM_OFS_U1_CTL 6'h18
`define CCM_OFS_U2_LO 6'h1C
`define CCM_OFS_U2_HI 6'h20
`define CCM_OFS_U2_CTL 6'h24
// Match flag, enable and priority bit positions
`define CCM_BIT_U1 1
`define CCM_BIT_U2 2
// Time base select bits in timer three control
`define CCM_BIT_TB_HI 6
`define CCM_BIT_TB_LO 3
// Compare mode encodings
`define CCM_MODE_SET 4'h8
`define CCM_MODE_CLR 4'h9
`define CCM_MODE_TGL 4'h2
`define CCM_MODE_SWI 4'hA
`define CCM_MODE_SEV 4'hB
// Implemented control bits and reset value
`define CCM_CTL_W 6
`define CCM_REG_RST 8'h00
// Bus responses
`define CCM_RESP_OK 2'h0
`define CCM_RESP_ERR 2'h2
`endif

// file: ccm_pkg.sv
package ccm_pkg;
    // Decoded compare action, one-hot
    typedef enum logic [4:0] {
        CCM_ACT_NONE = 5'h01,
        CCM_ACT_SET = 5'h02,
        CCM_ACT_CLR = 5'h04,
        CCM_ACT_TGL = 5'h08,
        CCM_ACT_EVT = 5'h10
    } ccm_act_e;

    // Pin drive pair
    typedef struct packed {
        logic o;
        logic oe;
    } ccm_pin_s;

    // Per-unit state
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic [5:0] ctl;
        logic latch;
        logic eq;
    } ccm_unit_s;

    // Whole block state
    typedef struct packed {
        ccm_unit_s [1:0] u;
        logic [1:0] flag;
        logic [1:0] ien;
        logic [1:0] ipr;
        logic [7:0] t3ctl;
        logic aw_full;
        logic [5:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        ccm_pin_s pin_c;
        ccm_pin_s pin_e;
        ccm_pin_s pin_one;
        logic [1:0] irq;
        logic [1:0] prio;
        logic t1_rst;
        logic t3_rst;
        logic adc_go;
    } ccm_state_s;
endpackage

// file: ccm_top.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`include "ccm_params.svh"
// Functional notes
// - Unit two compares value to chosen timer
// - Match sets, clears, toggles or leaves pin
// - Match sets the unit flag same cycle
// - Writing zero to control clears latch
// - Mode 1010 only raises flag
// - Interrupt needs enable bit set
// - Mode 1011 emits special event trigger
// - Trigger resets that unit's time base
// - Unit two trigger starts enabled converter
// - Unit one trigger never starts conversion
// - Unimplemented bits read back zero
// - Timer three control picks time bases
// - Mux bit picks port C or E pin
module ccm_top (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [5:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [5:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    input wire logic [15:0] TIMER_ONE_COUNT,
    input wire logic [15:0] TIMER_THREE_COUNT,
    input wire logic ADC_ENABLED,
    input wire logic UNIT_TWO_PIN_MUX_BIT,
    input wire logic PORT_C_LATCH_ONE,
    input wire logic PORT_E_LATCH_SEVEN,
    input wire logic UNIT_ONE_PORT_LATCH,
    input wire logic [2:0] PIN_DIRECTION_BITS,
    output ccm_pkg::ccm_pin_s PORT_C_PIN_ONE,
    output ccm_pkg::ccm_pin_s PORT_E_PIN_SEVEN,
    output ccm_pkg::ccm_pin_s UNIT_ONE_PIN,
    output logic [1:0] MATCH_IRQ,
    output logic [1:0] IRQ_PRIORITY,
    output logic TIMER_ONE_RESET,
    output logic TIMER_THREE_RESET,
    output logic ADC_START
);
    import ccm_pkg::*;

    // Registered state and its next value
    ccm_state_s s_q;
    ccm_state_s s_d;

    // True for a mapped register offset
    function automatic logic addr_ok(input logic [5:0] a);
        case (a)
            `CCM_OFS_FLAGS, `CCM_OFS_ENABLES,
            `CCM_OFS_PRIORITY, `CCM_OFS_T3CTL,
            `CCM_OFS_U1_LO, `CCM_OFS_U1_HI,
            `CCM_OFS_U1_CTL, `CCM_OFS_U2_LO,
            `CCM_OFS_U2_HI, `CCM_OFS_U2_CTL: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    endfunction

    // Place a two-bit field at the unit bit positions
    function automatic logic [7:0] pair(input logic [1:0] v);
        pair = 8'h00;
        pair[`CCM_BIT_U1] = v[0];
        pair[`CCM_BIT_U2] = v[1];
    endfunction

    // Read data; unimplemented bits stay zero
    function automatic logic [31:0] rd(
        input ccm_state_s s,
        input logic [5:0] a
    );
        rd = 32'h0000_0000;
        case (a)
            `CCM_OFS_FLAGS: rd[7:0] = pair(s.flag);
            `CCM_OFS_ENABLES: rd[7:0] = pair(s.ien);
            `CCM_OFS_PRIORITY: rd[7:0] = pair(s.ipr);
            `CCM_OFS_T3CTL: rd[7:0] = s.t3ctl;
            `CCM_OFS_U1_LO: rd[7:0] = s.u[0].lo;
            `CCM_OFS_U1_HI: rd[7:0] = s.u[0].hi;
            `CCM_OFS_U1_CTL: rd[5:0] = s.u[0].ctl;
            `CCM_OFS_U2_LO: rd[7:0] = s.u[1].lo;
            `CCM_OFS_U2_HI: rd[7:0] = s.u[1].hi;
            `CCM_OFS_U2_CTL: rd[5:0] = s.u[1].ctl;
            default: rd = 32'h0000_0000;
        endcase
    endfunction

    // Mode field to action
    function automatic ccm_act_e act_of(input logic [3:0] m);
        case (m)
            `CCM_MODE_SET: act_of = CCM_ACT_SET;
            `CCM_MODE_CLR: act_of = CCM_ACT_CLR;
            `CCM_MODE_TGL: act_of = CCM_ACT_TGL;
            `CCM_MODE_SWI: act_of = CCM_ACT_NONE;
            `CCM_MODE_SEV: act_of = CCM_ACT_EVT;
            default: act_of = CCM_ACT_NONE;
        endcase
    endfunction

    // True when the mode is a compare mode
    function automatic logic is_cmp(input logic [3:0] m);
        is_cmp = (m == `CCM_MODE_SET) || (m == `CCM_MODE_CLR)
            || (m == `CCM_MODE_TGL) || (m == `CCM_MODE_SWI)
            || (m == `CCM_MODE_SEV);
    endfunction

    // True when the mode drives the pin from the latch
    function automatic logic drives(input logic [3:0] m);
        drives = (m == `CCM_MODE_SET) || (m == `CCM_MODE_CLR)
            || (m == `CCM_MODE_TGL);
    endfunction

    // Time base of a unit: 1 selects timer three
    function automatic logic tb_t3(
        input logic [7:0] t3c,
        input logic unit_two
    );
        if (t3c[`CCM_BIT_TB_HI]) begin
            tb_t3 = 1'b1;
        end else if (t3c[`CCM_BIT_TB_LO]) begin
            tb_t3 = unit_two;
        end else begin
            tb_t3 = 1'b0;
        end
    endfunction

    // Working signals of the compare path
    logic [1:0] trig; // Special event per unit
    logic [1:0] sel3; // Unit uses timer three
    logic [1:0] hit; // Fresh match per unit
    logic [15:0] cnt [0:1]; // Selected count per unit
    logic [5:0] wa; // Write address
    logic [31:0] wd; // Write data
    logic wv; // Write performed this cycle

    // Next state: bus, registers, compare, pins
    always_comb begin
        s_d = s_q;
        trig = 2'b00;
        sel3 = 2'b00;
        hit = 2'b00;
        cnt[0] = 16'h0000;
        cnt[1] = 16'h0000;
        wa = 6'h00;
        wd = 32'h0000_0000;
        wv = 1'b0;
        // Retire the write answer
        if (s_q.bvalid && BREADY) begin
            s_d.bvalid = 1'b0;
        end
        // Capture write address
        if (AWVALID && s_q.awready) begin
            s_d.aw_full = 1'b1;
            s_d.awaddr = AWADDR;
        end
        // Capture write data
        if (WVALID && s_q.wready) begin
            s_d.w_full = 1'b1;
            s_d.wdata = WDATA;
            s_d.wstrb = WSTRB;
        end
        // Perform the write once both halves are held
        if (s_d.aw_full && s_d.w_full && !s_d.bvalid) begin
            wa = s_d.awaddr;
            wd = s_d.wdata;
            wv = s_d.wstrb[0] && addr_ok(wa);
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = addr_ok(wa) ? `CCM_RESP_OK
                                    : `CCM_RESP_ERR;
        end
        s_d.awready = !s_d.aw_full;
        s_d.wready = !s_d.w_full;
        // Register stores from the bus
        if (wv) begin
            case (wa)
                `CCM_OFS_FLAGS: begin
                    s_d.flag = {wd[`CCM_BIT_U2], wd[`CCM_BIT_U1]};
                end
                `CCM_OFS_ENABLES: begin
                    s_d.ien = {wd[`CCM_BIT_U2], wd[`CCM_BIT_U1]};
                end
                `CCM_OFS_PRIORITY: begin
                    s_d.ipr = {wd[`CCM_BIT_U2], wd[`CCM_BIT_U1]};
                end
                `CCM_OFS_T3CTL: s_d.t3ctl = wd[7:0];
                `CCM_OFS_U1_LO: s_d.u[0].lo = wd[7:0];
                `CCM_OFS_U1_HI: s_d.u[0].hi = wd[7:0];
                `CCM_OFS_U1_CTL: begin
                    s_d.u[0].ctl = wd[5:0];
                    if (wd[7:0] == 8'h00) begin
                        s_d.u[0].latch = 1'b0;
                    end
                end
                `CCM_OFS_U2_LO: s_d.u[1].lo = wd[7:0];
                `CCM_OFS_U2_HI: s_d.u[1].hi = wd[7:0];
                `CCM_OFS_U2_CTL: begin
                    s_d.u[1].ctl = wd[5:0];
                    if (wd[7:0] == 8'h00) begin
                        s_d.u[1].latch = 1'b0;
                    end
                end
                default: s_d.t3ctl = s_d.t3ctl;
            endcase
        end
        // Read channel: one read at a time
        if (ARVALID && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = rd(s_q, ARADDR);
            s_d.rresp = addr_ok(ARADDR) ? `CCM_RESP_OK
                                        : `CCM_RESP_ERR;
        end else if (s_q.rvalid && RREADY) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end
        // Compare each unit against its time base
        for (int i = 0; i < 2; i++) begin
            sel3[i] = tb_t3(s_q.t3ctl, i == 1);
            cnt[i] = sel3[i] ? TIMER_THREE_COUNT
                             : TIMER_ONE_COUNT;
            s_d.u[i].eq = cnt[i] == {s_q.u[i].hi, s_q.u[i].lo};
            // Act only on the first cycle of equality
            hit[i] = s_d.u[i].eq && !s_q.u[i].eq
                && is_cmp(s_q.u[i].ctl[3:0]);
            if (hit[i]) begin
                s_d.flag[i] = 1'b1;
                case (act_of(s_q.u[i].ctl[3:0]))
                    CCM_ACT_SET: s_d.u[i].latch = 1'b1;
                    CCM_ACT_CLR: s_d.u[i].latch = 1'b0;
                    CCM_ACT_TGL: begin
                        s_d.u[i].latch = !s_q.u[i].latch;
                    end
                    CCM_ACT_EVT: trig[i] = 1'b1;
                    default: trig[i] = 1'b0;
                endcase
            end
        end
        // Trigger resets whichever timer the unit uses
        s_d.t1_rst = |(trig & ~sel3);
        s_d.t3_rst = |(trig & sel3);
        // Only unit two starts the converter
        s_d.adc_go = trig[1] && ADC_ENABLED;
        // Request reaches the processor only if enabled
        s_d.irq = s_d.flag & s_d.ien;
        s_d.prio = s_d.ipr;
        // Unit two drives port C or port E
        s_d.pin_c.o = PORT_C_LATCH_ONE;
        s_d.pin_e.o = PORT_E_LATCH_SEVEN;
        if (drives(s_d.u[1].ctl[3:0])) begin
            if (UNIT_TWO_PIN_MUX_BIT) begin
                s_d.pin_c.o = s_d.u[1].latch;
            end else begin
                s_d.pin_e.o = s_d.u[1].latch;
            end
        end
        // Unit one pin
        s_d.pin_one.o = drives(s_d.u[0].ctl[3:0])
            ? s_d.u[0].latch : UNIT_ONE_PORT_LATCH;
        // Direction bit low means the pin is driven
        s_d.pin_c.oe = !PIN_DIRECTION_BITS[0];
        s_d.pin_e.oe = !PIN_DIRECTION_BITS[1];
        s_d.pin_one.oe = !PIN_DIRECTION_BITS[2];
    end

    // State register with synchronous reset
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            s_q <= '0;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register
    assign AWREADY = s_q.awready;
    assign WREADY = s_q.wready;
    assign BVALID = s_q.bvalid;
    assign BRESP = s_q.bresp;
    assign ARREADY = s_q.arready;
    assign RVALID = s_q.rvalid;
    assign RDATA = s_q.rdata;
    assign RRESP = s_q.rresp;
    assign PORT_C_PIN_ONE = s_q.pin_c;
    assign PORT_E_PIN_SEVEN = s_q.pin_e;
    assign UNIT_ONE_PIN = s_q.pin_one;
    assign MATCH_IRQ = s_q.irq;
    assign IRQ_PRIORITY = s_q.prio;
    assign TIMER_ONE_RESET = s_q.t1_rst;
    assign TIMER_THREE_RESET = s_q.t3_rst;
    assign ADC_START = s_q.adc_go;
endmodule

// file: ccm_top_assertions.sv
`timescale 1ns/100ps
// Watches bus handshakes, event pulses and the unit one pin enable of the block
module ccm_top_assertions (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic ADC_ENABLED,
    input wire logic [2:0] PIN_DIRECTION_BITS,
    input wire ccm_pkg::ccm_pin_s UNIT_ONE_PIN,
    input wire logic TIMER_ONE_RESET,
    input wire logic TIMER_THREE_RESET,
    input wire logic ADC_START
);
    import ccm_pkg::*;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    // Address and data taken on one edge
    sequence s_aw_taken;
        AWVALID && AWREADY;
    endsequence
    sequence s_both_taken;
        s_aw_taken ##0 (WVALID && WREADY);
    endsequence
    // A taken address is either answered at once or held off
    property p_aw_refuse;
        s_aw_taken |=> BVALID || !AWREADY;
    endproperty
    a_aw_refuse: assert property (p_aw_refuse)
        else $error("second write address accepted");
    property p_w_answer;
        s_both_taken |=> BVALID;
    endproperty
    a_w_answer: assert property (p_w_answer)
        else $error("write answer late");
    // Retired answer with no write held or arriving
    property p_b_retire;
        BVALID && BREADY && AWREADY && WREADY && !(AWVALID && WVALID)
            |=> !BVALID;
    endproperty
    a_b_retire: assert property (p_b_retire)
        else $error("write answer repeated");
    property p_r_refuse;
        RVALID |-> !ARREADY;
    endproperty
    a_r_refuse: assert property (p_r_refuse)
        else $error("read address open while answering");
    property p_t1_pulse;
        TIMER_ONE_RESET |=> !TIMER_ONE_RESET;
    endproperty
    a_t1_pulse: assert property (p_t1_pulse)
        else $error("timer one reset longer than one cycle");
    property p_t3_pulse;
        TIMER_THREE_RESET |=> !TIMER_THREE_RESET;
    endproperty
    a_t3_pulse: assert property (p_t3_pulse)
        else $error("timer three reset longer than one cycle");
    property p_adc_gate;
        ADC_START |-> $past(ADC_ENABLED);
    endproperty
    a_adc_gate: assert property (p_adc_gate)
        else $error("conversion started while converter off");
    property p_adc_pair;
        ADC_START |-> TIMER_ONE_RESET || TIMER_THREE_RESET;
    endproperty
    a_adc_pair: assert property (p_adc_pair)
        else $error("conversion start without trigger");
    property p_oe_one;
        !SYS_RST |=> UNIT_ONE_PIN.oe == !$past(PIN_DIRECTION_BITS[2]);
    endproperty
    a_oe_one: assert property (p_oe_one)
        else $error("unit one pin enable wrong");
endmodule

bind ccm_top ccm_top_assertions u_chk (.CLOCK, .SYS_RST, .AWVALID,
    .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .ARREADY, .RVALID,
    .ADC_ENABLED, .PIN_DIRECTION_BITS, .UNIT_ONE_PIN, .TIMER_ONE_RESET,
    .TIMER_THREE_RESET, .ADC_START);

// file: ccm_timers.sv
`timescale 1ns/100ps
// Timer pairs and converter that sit beside the compare block
module ccm_timers (
    input wire logic clk,
    input wire logic run,
    input wire logic clr,
    input wire logic t1_rst,
    input wire logic t3_rst,
    input wire logic adc_start,
    output logic [15:0] t1,
    output logic [15:0] t3,
    output logic [7:0] n1,
    output logic [7:0] n3,
    output logic [7:0] na
);
    // Counts on the block clock, cleared by trigger pulses
    always_ff @(posedge clk) begin
        if (clr) begin
            t1 <= 16'h0000;
            t3 <= 16'h0000;
            n1 <= 8'h00;
            n3 <= 8'h00;
            na <= 8'h00;
        end else begin
            t1 <= t1_rst ? 16'h0000 : t1 + {15'h0000, run};
            t3 <= t3_rst ? 16'h0000 : t3 + {15'h0000, run};
            n1 <= n1 + {7'h00, t1_rst};
            n3 <= n3 + {7'h00, t3_rst};
            na <= na + {7'h00, adc_start};
        end
    end
endmodule

// file: ccm_top_test.sv
`timescale 1ns/100ps
`include "ccm_params.svh"
module ccm_top_test;
    import ccm_pkg::*;
    logic CLOCK, SYS_RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ADC_ENABLED;
    logic [5:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, MATCH_IRQ, IRQ_PRIORITY;
    logic [15:0] TIMER_ONE_COUNT, TIMER_THREE_COUNT;
    logic UNIT_TWO_PIN_MUX_BIT, PORT_C_LATCH_ONE, PORT_E_LATCH_SEVEN;
    logic UNIT_ONE_PORT_LATCH, TIMER_ONE_RESET, TIMER_THREE_RESET;
    logic ADC_START, run, clr;
    logic [2:0] PIN_DIRECTION_BITS;
    ccm_pin_s PORT_C_PIN_ONE, PORT_E_PIN_SEVEN, UNIT_ONE_PIN;
    logic [7:0] n1, n3, nadc;
    logic [3:0] md [4] = '{`CCM_MODE_SET, `CCM_MODE_CLR, `CCM_MODE_TGL,
        `CCM_MODE_SWI};
    logic [7:0] c1 [4] = '{8'h00, 8'h00, 8'h0B, 8'h0B};
    logic [7:0] c2 [4] = '{8'h0B, 8'h0B, 8'h00, 8'h00};
    logic [7:0] tb [4] = '{8'h08, 8'h00, 8'h08, 8'h40};
    logic [2:0] ev [4] = '{3'h3, 3'h4, 3'h4, 3'h2};
    int n_fail, cmp_count;
    ccm_top u_dut (.CLOCK, .SYS_RST, .AWVALID, .AWREADY, .AWADDR, .WVALID,
        .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID,
        .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
        .TIMER_ONE_COUNT, .TIMER_THREE_COUNT, .ADC_ENABLED,
        .UNIT_TWO_PIN_MUX_BIT, .PORT_C_LATCH_ONE, .PORT_E_LATCH_SEVEN,
        .UNIT_ONE_PORT_LATCH, .PIN_DIRECTION_BITS, .PORT_C_PIN_ONE,
        .PORT_E_PIN_SEVEN, .UNIT_ONE_PIN, .MATCH_IRQ, .IRQ_PRIORITY,
        .TIMER_ONE_RESET, .TIMER_THREE_RESET, .ADC_START);
    ccm_timers u_tmr (.clk(CLOCK), .run(run), .clr(clr),
        .t1_rst(TIMER_ONE_RESET), .t3_rst(TIMER_THREE_RESET),
        .adc_start(ADC_START), .t1(TIMER_ONE_COUNT), .t3(TIMER_THREE_COUNT),
        .n1(n1), .n3(n3), .na(nadc));
    // Free running clock
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    // Verdict and end of run
    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus write: ready is judged just before the edge that takes it
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic aw, w, b;
        int n;
        b = 1'b0;
        n = 0;
        AWADDR <= a;
        WDATA <= {24'h000000, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (!b) begin
            @(negedge CLOCK);
            aw = AWVALID && AWREADY;
            w = WVALID && WREADY;
            b = BVALID;
            @(posedge CLOCK);
            if (aw) AWVALID <= 1'b0;
            if (w) WVALID <= 1'b0;
            n++;
            if (n > 50) begin
                n_fail++;
                summarize();
            end
        end
    endtask
    // Bus read with expected data and response
    task automatic rd(input logic [5:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic ar, r;
        logic [31:0] d;
        logic [1:0] rr;
        int n;
        r = 1'b0;
        n = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        while (!r) begin
            @(negedge CLOCK);
            ar = ARVALID && ARREADY;
            r = RVALID;
            d = RDATA;
            rr = RRESP;
            @(posedge CLOCK);
            if (ar) ARVALID <= 1'b0;
            n++;
            if (n > 50) begin
                n_fail++;
                summarize();
            end
        end
        chk(d, e);
        chk({30'h0, rr}, {30'h0, er});
    endtask
    // Restart timers from zero and let them count n edges
    task automatic sweep(input int n);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        run <= 1'b1;
        tick(n);
        run <= 1'b0;
        tick(2);
    endtask
    initial begin
        {SYS_RST, BREADY, RREADY, WSTRB} = 7'h7F;
        {AWVALID, WVALID, ARVALID, AWADDR, ARADDR, WDATA} = '0;
        {ADC_ENABLED, PORT_E_LATCH_SEVEN, UNIT_ONE_PORT_LATCH, run} = '0;
        {UNIT_TWO_PIN_MUX_BIT, PORT_C_LATCH_ONE, clr} = 3'h7;
        PIN_DIRECTION_BITS = 3'h0;
        n_fail = 0;
        cmp_count = 0;
        tick(10);
        SYS_RST <= 1'b0;
        tick(1);
        rd(`CCM_OFS_U2_CTL, 32'h0, `CCM_RESP_OK);
        wr(`CCM_OFS_ENABLES, 8'hFF);
        rd(`CCM_OFS_ENABLES, 32'h06, `CCM_RESP_OK);
        wr(`CCM_OFS_U2_CTL, 8'hFF);
        rd(`CCM_OFS_U2_CTL, 32'h3F, `CCM_RESP_OK);
        rd(6'h3C, 32'h0, `CCM_RESP_ERR);
        // Priority bit of unit one reaches its output
        wr(`CCM_OFS_PRIORITY, 8'h02);
        chk({30'h0, IRQ_PRIORITY}, 32'h1);
        rd(`CCM_OFS_PRIORITY, 32'h02, `CCM_RESP_OK);
        wr(`CCM_OFS_ENABLES, 8'h00);
        wr(`CCM_OFS_U2_LO, 8'h10);
        wr(`CCM_OFS_U2_HI, 8'h00);
        wr(`CCM_OFS_U1_LO, 8'h10);
        wr(`CCM_OFS_T3CTL, 8'h00);
        // Set, clear, toggle and flag-only modes from a cleared latch
        for (int i = 0; i < 4; i++) begin
            wr(`CCM_OFS_FLAGS, 8'h00);
            wr(`CCM_OFS_U2_CTL, 8'h00);
            wr(`CCM_OFS_U2_CTL, {4'h0, md[i]});
            sweep(40);
            chk({31'h0, PORT_C_PIN_ONE.o}, {31'h0, i != 1});
            rd(`CCM_OFS_FLAGS, 32'h04, `CCM_RESP_OK);
        end
        chk({30'h0, MATCH_IRQ}, 32'h0);
        wr(`CCM_OFS_ENABLES, 8'h04);
        tick(1);
        chk({30'h0, MATCH_IRQ}, 32'h2);
        // Held equality toggles once
        wr(`CCM_OFS_U2_CTL, 8'h00);
        wr(`CCM_OFS_U2_CTL, {4'h0, `CCM_MODE_TGL});
        sweep(16);
        tick(8);
        chk({31'h0, PORT_C_PIN_ONE.o}, 32'h1);
        tick(1);
        chk({31'h0, PORT_C_PIN_ONE.o}, 32'h1);
        // Pin on port E, then latch cleared by control write
        UNIT_TWO_PIN_MUX_BIT <= 1'b0;
        PORT_C_LATCH_ONE <= 1'b0;
        wr(`CCM_OFS_U2_CTL, 8'h00);
        wr(`CCM_OFS_U2_CTL, {4'h0, `CCM_MODE_SET});
        sweep(40);
        chk({30'h0, PORT_E_PIN_SEVEN}, 32'h3);
        chk({31'h0, PORT_C_PIN_ONE.o}, 32'h0);
        wr(`CCM_OFS_U2_CTL, 8'h00);
        wr(`CCM_OFS_U2_CTL, {4'h0, `CCM_MODE_SET});
        tick(1);
        chk({31'h0, PORT_E_PIN_SEVEN.o}, 32'h0);
        // Trigger: bits are timer one, timer three, conversion seen
        for (int i = 0; i < 4; i++) begin
            ADC_ENABLED <= i != 1;
            wr(`CCM_OFS_U1_CTL, c1[i]);
            wr(`CCM_OFS_U2_CTL, c2[i]);
            wr(`CCM_OFS_T3CTL, tb[i]);
            sweep(40);
            chk({29'h0, n1 != 0, n3 != 0, nadc != 0}, {29'h0, ev[i]});
        end
        // Unit one drives its own pin on timer three
        wr(`CCM_OFS_U1_CTL, 8'h00);
        wr(`CCM_OFS_U1_CTL, {4'h0, `CCM_MODE_SET});
        sweep(40);
        chk({30'h0, UNIT_ONE_PIN}, 32'h3);
        summarize();
    end
endmodule
